// ===== hdl/bfs_top.sv
// Fault supervisor for a two-phase boost controller.
// Assumes comparator outcomes arrive asynchronous and the PWM path
// delivers raw gate requests per phase that this block gates.
`timescale 1ns/1ps

module bfs_top
    import bfs_pkg::*;
#(
    parameter int HICCUP_COUNT = bfs_pkg::HICCUP_CYC,
    parameter int PG_COUNT = bfs_pkg::PG_DELAY_CYC
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Sequencer.
    input wire logic i_enable,
    input wire logic i_fault_response_select,
    input wire logic i_soft_start_active,
    // Comparators.
    input wire logic i_input_overvoltage_fault_cmp,
    input wire logic i_fb_ov_cmp,
    input wire logic i_fb_ov_clear_cmp,
    input wire logic i_fb_uv_cmp,
    input wire logic i_fb_uv_clear_cmp,
    input wire logic [bfs_pkg::PHASES-1:0] i_cur_limit_cmp,
    input wire logic [bfs_pkg::PHASES-1:0] i_cur_neg_cmp,
    input wire logic [bfs_pkg::PHASES-1:0] i_cur_fault_cmp,
    // PWM path.
    input wire logic [bfs_pkg::PHASES-1:0] i_cycle_start,
    input wire logic [bfs_pkg::PHASES-1:0] i_low_side_req,
    input wire logic [bfs_pkg::PHASES-1:0] i_high_side_req,
    output logic [bfs_pkg::PHASES-1:0] o_low_side_gate,
    output logic [bfs_pkg::PHASES-1:0] o_high_side_gate,
    // Status.
    output logic o_soft_start_req,
    output logic o_switching_en,
    output logic o_power_good_out,
    output logic o_input_overvoltage_fault,
    output logic o_output_overvoltage_fault,
    output logic o_output_undervoltage_flag,
    output logic o_peak_overcurrent_fault,
    output logic [bfs_pkg::PHASES-1:0] o_peak_current_cycle_limit,
    output logic [bfs_pkg::PHASES-1:0] o_negative_current_cycle_limit
);
    localparam int NS = 5 + 3 * PHASES;
    localparam logic [CNT_W-1:0] VIN_LOAD = CNT_W'(VIN_FILTER_CYC - 1);
    localparam logic [CNT_W-1:0] PG_LOAD = CNT_W'(PG_COUNT - 1);
    localparam logic [CNT_W-1:0] HIC_LOAD = CNT_W'(HICCUP_COUNT - 1);

    logic rst_m;
    logic rst_n;
    logic [NS-1:0] raw;
    logic [NS-1:0] syn;
    logic vin_cmp, fbov, fbov_clr, fbuv, fbuv_clr;
    logic [PHASES-1:0] lim_cmp, neg_cmp, oc2_cmp;
    bfs_state_e state;
    bfs_state_e next_state;
    logic vin_flag, ov_flag, oc_flag, uv_flag;
    logic vin_done, pg_done, hic_done;
    logic enable_q;
    logic [PHASES-1:0] lim_hold, neg_hold;

    // Reset released through two flops; asserts at once.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // All comparators pass one synchroniser.
    assign raw = {i_input_overvoltage_fault_cmp, i_fb_ov_cmp, i_fb_ov_clear_cmp, i_fb_uv_cmp,
                  i_fb_uv_clear_cmp, i_cur_limit_cmp, i_cur_neg_cmp,
                  i_cur_fault_cmp};
    bfs_sync #(.W(NS)) u_sync
    (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_async(raw),
        .o_sync(syn)
    );
    assign {vin_cmp, fbov, fbov_clr, fbuv, fbuv_clr, lim_cmp, neg_cmp,
            oc2_cmp} = syn;

    // Input overvoltage filter: comparator must hold for the full time.
    bfs_timer #(.W(CNT_W)) u_vin
    (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_load(!vin_cmp),
        .i_count(VIN_LOAD),
        .i_run(vin_cmp),
        .o_done(vin_done)
    );

    // Detection is armed from soft-start onward, i.e. while running.
    wire armed = (state == BFS_RUN);
    wire vin_trip = armed && vin_cmp && vin_done;
    wire ov_trip = armed && fbov;
    wire oc_trip = armed && (|oc2_cmp);
    wire any_trip = vin_trip || ov_trip || oc_trip;
    // Each fault's own clear condition; output overvoltage uses hysteresis.
    wire vin_clear = !vin_cmp;
    wire ov_clear = fbov_clr;
    wire oc_clear = !(|oc2_cmp);
    wire all_clear = (!vin_flag || vin_clear) && (!ov_flag || ov_clear)
                     && (!oc_flag || oc_clear);
    wire en_rise = i_enable && !enable_q;

    // Supervisor state selection.
    always_comb
    begin
        next_state = state;
        case (state)
            BFS_IDLE:
                if (en_rise)
                    next_state = BFS_RUN;
            BFS_RUN:
                if (!i_enable)
                    next_state = BFS_IDLE;
                else if (any_trip)
                    next_state = i_fault_response_select ? BFS_HICCUP
                                                         : BFS_LATCHED;
            BFS_HICCUP:
                if (!i_enable)
                    next_state = BFS_IDLE;
                else if (hic_done && all_clear)
                    next_state = BFS_RUN;
            BFS_LATCHED:
                if (!i_enable)
                    next_state = BFS_IDLE;
            default:
                next_state = BFS_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= BFS_IDLE;
            enable_q <= 1'b0;
        end
        else
        begin
            state <= next_state;
            enable_q <= i_enable;
        end
    end

    // Fault flags: trips set, clearing happens on re-entering run.
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vin_flag <= 1'b0;
            ov_flag <= 1'b0;
            oc_flag <= 1'b0;
        end
        else if (next_state == BFS_RUN && state != BFS_RUN)
        begin
            vin_flag <= 1'b0;
            ov_flag <= 1'b0;
            oc_flag <= 1'b0;
        end
        else
        begin
            vin_flag <= vin_flag | vin_trip;
            ov_flag <= ov_flag | ov_trip;
            oc_flag <= oc_flag | oc_trip;
        end
    end

    // Hiccup wait starts when the stop happens.
    bfs_timer #(.W(CNT_W)) u_hic
    (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_load(state != BFS_HICCUP),
        .i_count(HIC_LOAD),
        .i_run(1'b1),
        .o_done(hic_done)
    );

    // Undervoltage flag uses a hysteresis pair: set below, clear above.
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            uv_flag <= 1'b0;
        else if (fbuv)
            uv_flag <= 1'b1;
        else if (fbuv_clr)
            uv_flag <= 1'b0;
    end

    // Power-good needs every condition good for the whole delay.
    wire pg_ok = (state == BFS_RUN) && !uv_flag && !any_trip;
    bfs_timer #(.W(CNT_W)) u_pg
    (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_load(!pg_ok),
        .i_count(PG_LOAD),
        .i_run(1'b1),
        .o_done(pg_done)
    );

    // Per-phase cycle limits hold until the next cycle start.
    // Positive limit beats its own cycle start so a trip is never lost.
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lim_hold <= '0;
            neg_hold <= '0;
        end
        else
        begin
            lim_hold <= lim_cmp | (lim_hold & ~i_cycle_start);
            neg_hold <= neg_cmp | (neg_hold & ~i_cycle_start);
        end
    end

    // Gating: the enable drops in the same cycle as the trip; the registered gates go off at the next edge.
    // Undervoltage and cycle limits never enter this term.
    wire sw_en = (state == BFS_RUN) && !any_trip && i_enable;
    wire [PHASES-1:0] lim_now = lim_cmp | lim_hold;
    wire [PHASES-1:0] neg_now = neg_cmp | neg_hold;

    // Gate outputs registered for glitch-free drive.
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_low_side_gate <= '0;
            o_high_side_gate <= '0;
        end
        else
        begin
            o_low_side_gate <= i_low_side_req & ~lim_now
                               & {PHASES{sw_en}};
            o_high_side_gate <= i_high_side_req & ~neg_now
                                & {PHASES{sw_en}};
        end
    end

    // Status outputs.
    assign o_switching_en = sw_en;
    assign o_soft_start_req = (state == BFS_RUN) && !enable_q ? 1'b0
                              : (state != BFS_RUN && next_state == BFS_RUN);
    assign o_power_good_out = pg_done && pg_ok;
    assign o_input_overvoltage_fault = vin_flag;
    assign o_output_overvoltage_fault = ov_flag;
    assign o_output_undervoltage_flag = uv_flag;
    assign o_peak_overcurrent_fault = oc_flag;
    assign o_peak_current_cycle_limit = lim_now;
    assign o_negative_current_cycle_limit = neg_now;

    // Checks.
    a_stop_on_trip: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        any_trip |=> o_low_side_gate == '0 && o_high_side_gate == '0)
        else $error("gates not off after fault");
    a_latch_hold: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        state == BFS_LATCHED && i_enable |=> state == BFS_LATCHED)
        else $error("latch-off left while enabled");
    // The select level that counts is the one seen at the trip edge.
    a_hiccup_pick: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        state == BFS_RUN && i_enable && any_trip
        |=> state == ($past(i_fault_response_select) ? BFS_HICCUP
                                                      : BFS_LATCHED))
        else $error("wrong fault response");
    a_pg_low_fault: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        (vin_flag || ov_flag || uv_flag) |-> !o_power_good_out)
        else $error("power-good high during fault");
    a_pg_delay: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        $rose(o_power_good_out) |-> $past(pg_ok, 2))
        else $error("power-good released early");
    // Undervoltage must never move the supervisor out of run.
    a_uv_no_stop: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        uv_flag && state == BFS_RUN && i_enable && !any_trip
        |=> state == BFS_RUN)
        else $error("undervoltage stopped switching");
    a_low_cut: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        lim_cmp[0] |=> !o_low_side_gate[0])
        else $error("low-side not cut on limit");
    a_high_cut: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        neg_cmp[1] |=> !o_high_side_gate[1])
        else $error("high-side not cut on negative limit");
    a_oc_fault: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        state == BFS_RUN && |oc2_cmp |=> oc_flag)
        else $error("peak fault not flagged");
    a_hiccup_wait: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        $rose(state == BFS_HICCUP) |=> state == BFS_HICCUP [*8])
        else $error("hiccup retried too soon");
    c_hiccup: cover property (@(posedge i_mclk) state == BFS_HICCUP);
    c_latched: cover property (@(posedge i_mclk) state == BFS_LATCHED);
    c_pg_rise: cover property (@(posedge i_mclk) $rose(o_power_good_out));
endmodule // bfs_top

// ===== hdl/bfs_pkg.sv
// Package for the boost fault supervisor: timing constants and states.
// Assumes a 100 MHz controller clock.
package bfs_pkg;
    // Clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 10;
    // Input overvoltage filter time, least, in nanoseconds.
    localparam int VIN_FILTER_NS = 5000;
    localparam int VIN_FILTER_CYC =
        (VIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Power-good release delay, in microseconds.
    localparam int PG_DELAY_US = 500;
    localparam int PG_DELAY_CYC = PG_DELAY_US * 1000 / CLK_PERIOD_NS;
    // Hiccup retry wait, in milliseconds.
    localparam int HICCUP_MS = 500;
    localparam int HICCUP_CYC = HICCUP_MS * 100000;
    // Counter widths.
    localparam int CNT_W = 26;
    // Number of phases.
    localparam int PHASES = 2;

    // Supervisor states.
    typedef enum logic [1:0]
    {
        BFS_IDLE = 2'b00,
        BFS_RUN = 2'b01,
        BFS_HICCUP = 2'b10,
        BFS_LATCHED = 2'b11
    } bfs_state_e;
endpackage

// ===== hdl/bfs_sync.sv
// Two-flip-flop synchroniser for a vector of levels.
// Assumes the inputs are asynchronous comparator outcomes.
`timescale 1ns/1ps
module bfs_sync
#(
    parameter int W = 1
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Levels.
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    // The first stage is read only by the second stage.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule // bfs_sync

// ===== hdl/bfs_timer.sv
// Down-counting timer with a load and a done level.
// Assumes a single clock domain.
`timescale 1ns/1ps
module bfs_timer
#(
    parameter int W = 26
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Control.
    input wire logic i_load,
    input wire logic [W-1:0] i_count,
    input wire logic i_run,
    output logic o_done
);
    logic [W-1:0] cnt;

    // Done while the count is zero and not reloaded.
    assign o_done = (cnt == '0) && !i_load;

    // Load wins; otherwise count down while running.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt <= '0;
        else if (i_load)
            cnt <= i_count;
        else if (i_run && cnt != '0)
            cnt <= cnt - 1'b1;
    end
endmodule // bfs_timer

// ===== testbench/bfs_stage_model.sv
// Behavioural power stage: comparators and a two-phase PWM source.
// Assumes the bench sets voltages and currents as plain integers.
`timescale 1ns/1ps
module bfs_stage_model
(
    // Clock.
    input wire logic i_mclk,
    // Analog conditions set by the bench.
    input int i_vin_v,
    input int i_fb_pct,
    input int i_cur_ua [2],
    // Comparator outcomes.
    output logic o_input_overvoltage_fault_cmp,
    output logic o_fb_ov_cmp,
    output logic o_fb_ov_clear_cmp,
    output logic o_fb_uv_cmp,
    output logic o_fb_uv_clear_cmp,
    output logic [1:0] o_cur_limit_cmp,
    output logic [1:0] o_cur_neg_cmp,
    output logic [1:0] o_cur_fault_cmp,
    // Raw PWM requests.
    output logic [1:0] o_cycle_start,
    output logic [1:0] o_low_side_req,
    output logic [1:0] o_high_side_req
);
    logic [3:0] phase_cnt;
    initial phase_cnt = 4'h0;
    // Hysteresis is two separate levels, so a value between them trips none.
    assign o_input_overvoltage_fault_cmp = i_vin_v > 58;
    assign o_fb_ov_cmp = i_fb_pct > 120;
    assign o_fb_ov_clear_cmp = i_fb_pct < 116;
    assign o_fb_uv_cmp = i_fb_pct < 80;
    assign o_fb_uv_clear_cmp = i_fb_pct > 84;
    // Per-phase current thresholds.
    for (genvar p = 0; p < 2; p++)
    begin : g_phase
        assign o_cur_limit_cmp[p] = i_cur_ua[p] >= 80;
        assign o_cur_neg_cmp[p] = i_cur_ua[p] < -48;
        assign o_cur_fault_cmp[p] = i_cur_ua[p] >= 105;
    end
    // Phase 1 runs half a period behind phase 0, as an interleaved pair.
    always @(posedge i_mclk)
    begin
        phase_cnt <= phase_cnt + 4'h1;
    end
    // No dead time is modelled; the block under test only gates requests.
    assign o_cycle_start = {phase_cnt == 4'h8, phase_cnt == 4'h0};
    assign o_low_side_req = {phase_cnt[3], ~phase_cnt[3]};
    assign o_high_side_req = ~o_low_side_req;
endmodule // bfs_stage_model

// ===== testbench/bfs_top_tb.sv
// Self-checking bench for the boost fault supervisor.
// Assumes the stage model answers at once to the bench's conditions.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    failures++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module bfs_top_tb;
    import bfs_pkg::*;
    localparam int HIC = 20;
    localparam int PGC = 10;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic enable = 1'b0;
    logic resp_sel = 1'b1;
    int vin_v = 12;
    int fb_pct = 100;
    int cur_ua [2] = '{0, 0};
    int failures = 0;
    int tests_run = 0;
    logic vin_cmp, ov_cmp, ov_clr, uv_cmp, uv_clr, ss_req, sw_en, pg;
    logic vin_f, ov_f, uv_f, pk_f;
    logic [1:0] lim_cmp, neg_cmp, flt_cmp, cyc, lo_req, hi_req;
    logic [1:0] lo_gate, hi_gate, lim, negl;
    // Free-running 100 MHz clock.
    always #5 mclk = ~mclk;
    // Design and stage model.
    bfs_top #(.HICCUP_COUNT(HIC), .PG_COUNT(PGC)) u_bfs_top (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_enable(enable),
        .i_fault_response_select(resp_sel), .i_soft_start_active(1'b0),
        .i_input_overvoltage_fault_cmp(vin_cmp), .i_fb_ov_cmp(ov_cmp),
        .i_fb_ov_clear_cmp(ov_clr), .i_fb_uv_cmp(uv_cmp),
        .i_fb_uv_clear_cmp(uv_clr), .i_cur_limit_cmp(lim_cmp),
        .i_cur_neg_cmp(neg_cmp), .i_cur_fault_cmp(flt_cmp),
        .i_cycle_start(cyc), .i_low_side_req(lo_req),
        .i_high_side_req(hi_req), .o_low_side_gate(lo_gate),
        .o_high_side_gate(hi_gate), .o_soft_start_req(ss_req),
        .o_switching_en(sw_en), .o_power_good_out(pg),
        .o_input_overvoltage_fault(vin_f),
        .o_output_overvoltage_fault(ov_f),
        .o_output_undervoltage_flag(uv_f), .o_peak_overcurrent_fault(pk_f),
        .o_peak_current_cycle_limit(lim),
        .o_negative_current_cycle_limit(negl));
    bfs_stage_model u_bfs_stage_model (
        .i_mclk(mclk), .i_vin_v(vin_v), .i_fb_pct(fb_pct),
        .i_cur_ua(cur_ua), .o_input_overvoltage_fault_cmp(vin_cmp), .o_fb_ov_cmp(ov_cmp),
        .o_fb_ov_clear_cmp(ov_clr), .o_fb_uv_cmp(uv_cmp),
        .o_fb_uv_clear_cmp(uv_clr), .o_cur_limit_cmp(lim_cmp),
        .o_cur_neg_cmp(neg_cmp), .o_cur_fault_cmp(flt_cmp),
        .o_cycle_start(cyc), .o_low_side_req(lo_req),
        .o_high_side_req(hi_req));
    // Inputs change only at the falling edge.
    task automatic ticks(int n);
        repeat (n) @(negedge mclk);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Waits, bounded, for power-good and checks it was not early.
    // The count starts from the cycles already spent since recovery.
    task automatic pg_release(int spent);
        int n;
        n = spent;
        while (pg !== 1'b1 && n < PGC + 20)
        begin
            ticks(1);
            n++;
        end
        `CHK("pg_late", 1'b1, pg)
        `CHK("pg_early", 1'b1, n >= PGC - 2)
    endtask
    // Counts gate-on cycles of each phase over one switching period.
    // Four-state counters, so an unknown gate poisons the count.
    task automatic count_gates(output integer l0, output integer l1,
                               output integer h0, output integer h1);
        l0 = 0;
        l1 = 0;
        h0 = 0;
        h1 = 0;
        repeat (16)
        begin
            ticks(1);
            l0 += lo_gate[0];
            l1 += lo_gate[1];
            h0 += hi_gate[0];
            h1 += hi_gate[1];
        end
    endtask
    // Enable starts switching; power-good waits its delay.
    task automatic start_up();
        enable = 1'b1;
        ticks(4);
        `CHK("sw_en", 1'b1, sw_en)
        `CHK("pg_hold", 1'b0, pg)
        pg_release(4);
    endtask
    // Undervoltage only lowers power-good, with a hysteresis band.
    task automatic uv_test();
        fb_pct = 70;
        ticks(6);
        `CHK("uv_flag", 1'b1, uv_f)
        `CHK("uv_pg", 1'b0, pg)
        `CHK("uv_sw", 1'b1, sw_en)
        fb_pct = 82;
        ticks(PGC + 20);
        `CHK("uv_band_pg", 1'b0, pg)
        `CHK("uv_band_sw", 1'b1, sw_en)
        fb_pct = 100;
        pg_release(0);
    endtask
    // Cycle limits cut one gate of one phase and never shut down.
    task automatic limit_test();
        integer l0, l1, h0, h1;
        cur_ua[0] = 90;
        cur_ua[1] = -60;
        ticks(20);
        count_gates(l0, l1, h0, h1);
        `CHK("lo0_cut", 1'b1, l0 == 0)
        `CHK("lo1_run", 1'b1, l1 > 0)
        `CHK("hi1_cut", 1'b1, h1 == 0)
        `CHK("hi0_run", 1'b1, h0 > 0)
        `CHK("lim", 2'b01, lim)
        `CHK("negl", 2'b10, negl)
        `CHK("lim_sw", 1'b1, sw_en)
        `CHK("lim_pk", 1'b0, pk_f)
        cur_ua = '{0, 0};
        ticks(40);
        count_gates(l0, l1, h0, h1);
        `CHK("lo0_back", 1'b1, l0 > 0)
        `CHK("hi1_back", 1'b1, h1 > 0)
    endtask
    // Shutdown fault k (input OV, output OV, peak current) in hiccup mode.
    task automatic hiccup_fault(int k);
        int n;
        logic ss_seen;
        ss_seen = 1'b0;
        n = 0;
        case (k)
            0: vin_v = 60;
            1: fb_pct = 130;
            default: cur_ua[0] = 110;
        endcase
        if (k == 0)
        begin
            ticks(450);
            `CHK("vin_filter", 1'b0, vin_f)
        end
        while (sw_en !== 1'b0 && n < 200)
        begin
            ticks(1);
            n++;
        end
        ticks(3);
        `CHK("flags", 3'b100 >> k, {vin_f, ov_f, pk_f})
        `CHK("stop", 1'b0, sw_en)
        `CHK("gates", 4'h0, {lo_gate, hi_gate})
        `CHK("pg_low", 1'b0, pg)
        n = 3;
        if (k > 0)
        begin
            fb_pct = (k == 1) ? 118 : 100;
            ticks(HIC + 20);
            n += HIC + 20;
            `CHK("held_off", 1'b0, sw_en)
        end
        vin_v = 12;
        fb_pct = 100;
        cur_ua[0] = 0;
        while (sw_en !== 1'b1 && n < HIC + 80)
        begin
            ticks(1);
            n++;
            ss_seen |= ss_req;
        end
        `CHK("resume", 1'b1, sw_en)
        `CHK("ss_req", 1'b1, ss_seen)
        `CHK("wait", 1'b1, n >= HIC)
        pg_release(0);
    endtask
    // Latch-off: armed in soft-start, stays off until enable toggles.
    task automatic latch_test();
        resp_sel = 1'b0;
        enable = 1'b0;
        ticks(3);
        enable = 1'b1;
        ticks(3);
        cur_ua[1] = 110;
        ticks(8);
        `CHK("armed", 1'b1, pk_f)
        `CHK("latched", 1'b0, sw_en)
        cur_ua[1] = 0;
        ticks(3 * HIC);
        `CHK("stays_off", 1'b0, sw_en)
        enable = 1'b0;
        ticks(3);
        enable = 1'b1;
        ticks(6);
        `CHK("restart", 1'b1, sw_en)
        resp_sel = 1'b1;
    endtask
    // Main sequence: reset held two cycles, then each scenario in turn.
    initial
    begin
        ticks(2);
        `CHK("rst_out", 4'h0, {pg, sw_en, lo_gate[0], hi_gate[0]})
        rst_n = 1'b1;
        ticks(5);
        start_up();
        uv_test();
        limit_test();
        for (int k = 0; k < 3; k++)
            hiccup_fault(k);
        latch_test();
        complete_run();
    end
    // Watchdog well beyond the thousand or so cycles the tests need.
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        complete_run();
    end
endmodule // bfs_top_tb
